// file: clk_src_ctrl.sv
// clock-source control: start-up counter, multiplier, source select, internal oscillators
`timescale 1ns/100ps
module clk_src_ctrl #(
  parameter int OST_CYCLES = clk_src_pkg::OST_COUNT,
  parameter int SETTLE_CYCLES = clk_src_pkg::SETTLE_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // register bus
  input wire clk_src_pkg::axi_req_t axi_req,
  output clk_src_pkg::axi_rsp_t axi_rsp,
  // configuration word bits
  input wire logic [2:0] osc_mode,
  input wire logic config_multiplier_enable,
  input wire logic clock_output_config_bit,
  input wire logic clock_failure_monitor,
  input wire logic dual_speed_enable,
  // start-up events, same clock domain
  input wire logic power_up_delay_done,
  input wire logic wake_pulse,
  // pin and analog status, asynchronous
  input wire logic primary_osc_input_pin,
  input wire logic fast_run_in,
  input wire logic fast_lock_in,
  input wire logic fast_stab_in,
  input wire logic mid_run_in,
  // clock path control
  output clk_src_pkg::sys_src_t sys_src,
  output logic multiplier_on,
  output logic cpu_hold,
  output logic run_internal,
  output logic startup_done,
  output logic fast_osc_enable,
  output logic fast_startup_osc_enable,
  output logic fast_loop_enable,
  output logic mid_osc_enable,
  output logic [3:0] postscale_sel,
  output logic [5:0] fast_tune,
  output logic [5:0] mid_tune,
  // oscillator pin functions
  output logic primary_pin_gpio,
  output logic secondary_pin_clock_out,
  output logic secondary_pin_gpio
);
  localparam int NSYNC = 5;
  localparam int CW = $clog2(OST_CYCLES + 1);
  localparam int SW = $clog2(SETTLE_CYCLES + 1);

  // software state
  logic [1:0] scs_r;
  logic [3:0] ifs_r;
  logic sw_mul_r;
  logic [5:0] tune_r;
  // bus state
  logic awready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  // synchronisers
  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] s1_r;
  logic [NSYNC-1:0] s2_r;
  logic [NSYNC-1:0] s3_r;
  logic [NSYNC-1:0] filt_r;
  logic pin_d_r;
  logic pin_rise;
  // start-up counter, mode decode, settle counter, bus strobes and register read views
  clk_src_pkg::ost_state_t st_r;
  logic [CW-1:0] cnt_r;
  logic crystal;
  logic internal_mode;
  logic [SW-1:0] settle_r;
  logic wr_fire;
  logic rd_fire;
  logic [7:0] ctrl_rd;
  logic [7:0] stat_rd;

  assign crystal = (osc_mode == clk_src_pkg::MODE_LOW_GAIN) ||
                   (osc_mode == clk_src_pkg::MODE_MED_GAIN) ||
                   (osc_mode == clk_src_pkg::MODE_HIGH_GAIN);
  assign internal_mode = (osc_mode == clk_src_pkg::MODE_INTERNAL);

  // three-stage synchronisers; a change counts only when stages two and three agree
  assign async_in = {mid_run_in, fast_stab_in, fast_lock_in, fast_run_in,
                     primary_osc_input_pin};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          s1_r[gi] <= 1'b0;
          s2_r[gi] <= 1'b0;
          s3_r[gi] <= 1'b0;
          filt_r[gi] <= 1'b0;
        end else begin
          s1_r[gi] <= async_in[gi];
          s2_r[gi] <= s1_r[gi];
          s3_r[gi] <= s2_r[gi];
          if (s2_r[gi] == s3_r[gi]) begin
            filt_r[gi] <= s3_r[gi];
          end
        end
      end
    end
  endgenerate

  // primary pin edge; pin must run well below a quarter of ref_clk
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pin_d_r <= 1'b0;
    end else begin
      pin_d_r <= filt_r[0];
    end
  end
  assign pin_rise = filt_r[0] && !pin_d_r;

  // start-up counter; a wake restarts it from zero wherever it stands
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= clk_src_pkg::ST_IDLE;
      cnt_r <= '0;
    end else if (wake_pulse) begin
      st_r <= crystal ? clk_src_pkg::ST_COUNT : clk_src_pkg::ST_DONE;
      cnt_r <= '0;
    end else begin
      case (st_r)
        clk_src_pkg::ST_IDLE: begin
          cnt_r <= '0;
          if (power_up_delay_done) begin
            st_r <= crystal ? clk_src_pkg::ST_COUNT : clk_src_pkg::ST_DONE;
          end
        end
        clk_src_pkg::ST_COUNT: begin
          if (pin_rise) begin
            if (cnt_r == CW'(OST_CYCLES - 1)) begin
              st_r <= clk_src_pkg::ST_DONE;
            end
            cnt_r <= cnt_r + 1'b1;
          end
        end
        clk_src_pkg::ST_DONE: begin
          st_r <= clk_src_pkg::ST_DONE;
        end
        default: begin
          st_r <= clk_src_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // execution control while the count runs
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      startup_done <= 1'b0;
      cpu_hold <= 1'b1;
      run_internal <= 1'b0;
    end else begin
      startup_done <= (st_r == clk_src_pkg::ST_DONE);
      cpu_hold <= (st_r != clk_src_pkg::ST_DONE) &&
                  !(clock_failure_monitor || dual_speed_enable);
      run_internal <= (st_r != clk_src_pkg::ST_DONE) && crystal &&
                      (clock_failure_monitor || dual_speed_enable);
    end
  end

  // source select, multiplier and pin functions
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sys_src <= clk_src_pkg::SRC_PRIMARY;
      multiplier_on <= 1'b0;
      primary_pin_gpio <= 1'b0;
      secondary_pin_clock_out <= 1'b0;
      secondary_pin_gpio <= 1'b0;
    end else begin
      if (scs_r[1]) begin
        sys_src <= clk_src_pkg::SRC_INTERNAL;
      end else if (scs_r[0]) begin
        sys_src <= clk_src_pkg::SRC_SECONDARY;
      end else begin
        sys_src <= clk_src_pkg::SRC_PRIMARY;
      end
      // config bit alone suffices, so software cannot turn it off
      multiplier_on <= config_multiplier_enable || sw_mul_r;
      primary_pin_gpio <= internal_mode;
      secondary_pin_clock_out <= (internal_mode || osc_mode == clk_src_pkg::MODE_RC) &&
                                 clock_output_config_bit;
      secondary_pin_gpio <= (internal_mode || osc_mode == clk_src_pkg::MODE_RC) &&
                            !clock_output_config_bit;
    end
  end

  // internal oscillator enables; fast needs mid as its loop reference
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      fast_osc_enable <= 1'b0;
      mid_osc_enable <= 1'b0;
      postscale_sel <= clk_src_pkg::IFS_RST;
      fast_tune <= clk_src_pkg::TUNE_RST;
      mid_tune <= clk_src_pkg::TUNE_RST;
    end else begin
      fast_osc_enable <= (ifs_r >= clk_src_pkg::IFS_FAST_MIN) &&
                         (internal_mode || scs_r[1]);
      mid_osc_enable <= (internal_mode || scs_r[1]) &&
                        (ifs_r >= clk_src_pkg::IFS_MID_MIN);
      postscale_sel <= ifs_r;
      // the slow oscillator has no tuning port at all
      fast_tune <= tune_r;
      mid_tune <= tune_r;
    end
  end

  // start-up oscillator runs until the settle time elapses, then the loop takes over
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      settle_r <= '0;
      fast_startup_osc_enable <= 1'b0;
      fast_loop_enable <= 1'b0;
    end else if (!fast_osc_enable) begin
      settle_r <= '0;
      fast_startup_osc_enable <= 1'b0;
      fast_loop_enable <= 1'b0;
    end else begin
      if (settle_r != SW'(SETTLE_CYCLES)) begin
        settle_r <= settle_r + 1'b1;
      end
      fast_startup_osc_enable <= (settle_r != SW'(SETTLE_CYCLES));
      fast_loop_enable <= (settle_r == SW'(SETTLE_CYCLES));
    end
  end

  // register read views
  assign ctrl_rd = {sw_mul_r, ifs_r, 1'b0, scs_r};
  assign stat_rd = {3'h0, startup_done, filt_r[4], filt_r[3], filt_r[2],
                    filt_r[1]};

  // write channel: address and data taken together, one write in flight
  assign wr_fire = awready_r;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      awready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= clk_src_pkg::RESP_OKAY;
    end else begin
      awready_r <= axi_req.awvalid && axi_req.wvalid && !awready_r && !bvalid_r;
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r <= (axi_req.awaddr == clk_src_pkg::CTRL_OFS ||
                    axi_req.awaddr == clk_src_pkg::STAT_OFS ||
                    axi_req.awaddr == clk_src_pkg::TUNE_OFS) ?
                   clk_src_pkg::RESP_OKAY : clk_src_pkg::RESP_SLVERR;
      end else if (bvalid_r && axi_req.bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // software registers; status is read-only and ignores writes
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      scs_r <= clk_src_pkg::SCS_RST;
      ifs_r <= clk_src_pkg::IFS_RST;
      sw_mul_r <= 1'b0;
      tune_r <= clk_src_pkg::TUNE_RST;
    end else if (wr_fire && axi_req.wstrb[0]) begin
      if (axi_req.awaddr == clk_src_pkg::CTRL_OFS) begin
        scs_r <= axi_req.wdata[clk_src_pkg::SCS_LSB +: 2];
        ifs_r <= axi_req.wdata[clk_src_pkg::IFS_LSB +: 4];
        sw_mul_r <= axi_req.wdata[clk_src_pkg::SWMUL_BIT];
      end
      if (axi_req.awaddr == clk_src_pkg::TUNE_OFS) begin
        tune_r <= axi_req.wdata[5:0];
      end
    end
  end

  // read channel: one read in flight
  assign rd_fire = arready_r;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= clk_src_pkg::RESP_OKAY;
    end else begin
      arready_r <= axi_req.arvalid && !arready_r && !rvalid_r;
      if (rd_fire) begin
        rvalid_r <= 1'b1;
        rresp_r <= clk_src_pkg::RESP_OKAY;
        case (axi_req.araddr)
          clk_src_pkg::CTRL_OFS: rdata_r <= {24'h000000, ctrl_rd};
          clk_src_pkg::STAT_OFS: rdata_r <= {24'h000000, stat_rd};
          clk_src_pkg::TUNE_OFS: rdata_r <= {26'h0000000, tune_r};
          default: begin
            rdata_r <= 32'h0000_0000;
            rresp_r <= clk_src_pkg::RESP_SLVERR;
          end
        endcase
      end else if (rvalid_r && axi_req.rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // bus outputs in one assignment, so the struct port has a single driver
  assign axi_rsp = '{awready: awready_r, wready: awready_r, bresp: bresp_r, bvalid: bvalid_r,
                     arready: arready_r, rdata: rdata_r, rresp: rresp_r, rvalid: rvalid_r};

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence s_last_edge;
    st_r == clk_src_pkg::ST_COUNT && pin_rise && cnt_r == CW'(OST_CYCLES - 1);
  endsequence
  property p_ost_done;
    s_last_edge |=> st_r == clk_src_pkg::ST_DONE ##1 startup_done;
  endproperty
  a_ost_done: assert property (p_ost_done) else $error("count end missed");

  property p_ost_early;
    $rose(startup_done) && crystal |-> $past(cnt_r, 2) == CW'(OST_CYCLES - 1);
  endproperty
  a_ost_early: assert property (p_ost_early) else $error("done too early");

  property p_wake;
    wake_pulse && crystal |=> st_r == clk_src_pkg::ST_COUNT && cnt_r == '0;
  endproperty
  a_wake: assert property (p_wake) else $error("wake not restarting");

  property p_hold;
    (st_r == clk_src_pkg::ST_COUNT && !clock_failure_monitor && !dual_speed_enable)
      ##1 (!clock_failure_monitor && !dual_speed_enable) |-> cpu_hold;
  endproperty
  a_hold: assert property (p_hold) else $error("core not held");

  property p_run_int;
    run_internal |-> !cpu_hold && $past(st_r) != clk_src_pkg::ST_DONE;
  endproperty
  a_run_int: assert property (p_run_int) else $error("internal run wrong");

  property p_mult;
    config_multiplier_enable |=> multiplier_on;
  endproperty
  a_mult: assert property (p_mult) else $error("multiplier off");

  property p_pins;
    !(secondary_pin_clock_out && secondary_pin_gpio);
  endproperty
  a_pins: assert property (p_pins) else $error("pin double use");

  property p_fast_mid;
    fast_osc_enable |-> mid_osc_enable;
  endproperty
  a_fast_mid: assert property (p_fast_mid) else $error("fast without mid");

  property p_settle;
    $rose(fast_loop_enable) |-> $past(fast_startup_osc_enable) && !fast_startup_osc_enable;
  endproperty
  a_settle: assert property (p_settle) else $error("loop before settle");

  property p_scs_src;
    scs_r == 2'h1 |=> sys_src == clk_src_pkg::SRC_SECONDARY;
  endproperty
  a_scs_src: assert property (p_scs_src) else $error("source select wrong");

  property p_wr_resp;
    awready_r |=> bvalid_r;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("no write response");
endmodule

// file: clk_src_pkg.sv
// package: offsets, fields, reset values, timing and types of the clock-source control
package clk_src_pkg;
  // register byte offsets
  localparam logic [31:0] CTRL_OFS = 32'h0000_0000;
  localparam logic [31:0] STAT_OFS = 32'h0000_0004;
  localparam logic [31:0] TUNE_OFS = 32'h0000_0008;
  // control register fields
  localparam int SCS_LSB = 0;
  localparam int IFS_LSB = 3;
  localparam int SWMUL_BIT = 7;
  // status register fields
  localparam int FAST_RDY_BIT = 0;
  localparam int FAST_LCK_BIT = 1;
  localparam int FAST_STB_BIT = 2;
  localparam int MID_RDY_BIT = 3;
  localparam int OST_DONE_BIT = 4;
  // reset values
  localparam logic [1:0] SCS_RST = 2'h0;
  localparam logic [3:0] IFS_RST = 4'h7;
  localparam logic [5:0] TUNE_RST = 6'h00;
  // oscillator mode codes of the configuration field
  localparam logic [2:0] MODE_LOW_GAIN = 3'h0;
  localparam logic [2:0] MODE_MED_GAIN = 3'h1;
  localparam logic [2:0] MODE_HIGH_GAIN = 3'h2;
  localparam logic [2:0] MODE_RC = 3'h3;
  localparam logic [2:0] MODE_INTERNAL = 3'h4;
  // frequency select decode
  localparam logic [3:0] IFS_MID_MIN = 4'h2;
  localparam logic [3:0] IFS_MID_MAX = 4'h7;
  localparam logic [3:0] IFS_FAST_MIN = 4'h8;
  // timing
  localparam int OST_COUNT = 1024;
  localparam int CLK_MHZ = 200;
  localparam int SETTLE_NS = 1000;
  localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_COUNT = 2'b01,
    ST_DONE = 2'b11
  } ost_state_t;

  typedef enum logic [1:0] {
    SRC_PRIMARY = 2'h0,
    SRC_SECONDARY = 2'h1,
    SRC_INTERNAL = 2'h2
  } sys_src_t;

  typedef struct packed {
    logic [31:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [31:0] araddr;
    logic arvalid;
    logic rready;
  } axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } axi_rsp_t;
endpackage

// file: clk_src_partner.sv
// partner model: crystal on the primary pin and analog oscillator status
`timescale 1ns/100ps
module clk_src_partner (
  // crystal control from the bench
  input wire logic xtal_run,
  // enables from the block
  input wire logic fast_loop_enable,
  input wire logic mid_osc_enable,
  // pin and analog status
  output logic pin,
  output logic fast_run,
  output logic fast_lock,
  output logic fast_stab,
  output logic mid_run
);
  // crystal toggles every 40 ns, offset from ref_clk edges; it freezes while stopped
  initial begin
    pin = 1'b0;
    fast_run = 1'b0;
    fast_lock = 1'b0;
    fast_stab = 1'b0;
    mid_run = 1'b0;
    #1;
    forever begin
      #40;
      if (xtal_run) pin = ~pin;
    end
  end
  // fast runs once its loop runs, locks later, settles later still
  always @(fast_loop_enable) begin
    fast_run <= #100 fast_loop_enable;
    fast_lock <= #300 fast_loop_enable;
    fast_stab <= #600 fast_loop_enable;
  end
  // mid runs shortly after its enable
  always @(mid_osc_enable) mid_run <= #50 mid_osc_enable;
endmodule

// file: system_clock_source_control_tb_top.sv
// testbench: bus tasks and directed sequences for the clock-source control
`timescale 1ns/100ps
module system_clock_source_control_tb_top;
  localparam int OSTN = 8;
  localparam int SETN = 4;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  clk_src_pkg::axi_req_t req = '0;
  clk_src_pkg::axi_rsp_t rsp;
  logic [2:0] mode = 3'h0;
  logic cfg_mul = 1'b0, clk_out_cfg = 1'b0, mon = 1'b0, dual = 1'b0, pwr_ok = 1'b0;
  logic wake = 1'b0, xtal_run = 1'b1;
  logic pin, f_run, f_lock, f_stab, m_run;
  clk_src_pkg::sys_src_t sys_src;
  logic mul_on, cpu_hold, run_int, st_done, f_en, f_su, f_loop, m_en, pgpio, s_ck, s_gpio;
  logic [3:0] psel;
  logic [5:0] f_tune, m_tune;
  logic [31:0] rd;
  logic [1:0] rs;
  logic fe, me;
  logic [3:0] ifs_tab [5] = '{4'h0, 4'h2, 4'h7, 4'h8, 4'hf};
  logic [2:0] mode_tab [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
  int n_mismatch = 0;
  int compares = 0;
  int pin_edges = 0;
  int n;

  clk_src_ctrl #(.OST_CYCLES(OSTN), .SETTLE_CYCLES(SETN)) DUT (
    .ref_clk(ref_clk), .resetn(resetn), .axi_req(req), .axi_rsp(rsp),
    .osc_mode(mode), .config_multiplier_enable(cfg_mul),
    .clock_output_config_bit(clk_out_cfg), .clock_failure_monitor(mon),
    .dual_speed_enable(dual), .power_up_delay_done(pwr_ok), .wake_pulse(wake),
    .primary_osc_input_pin(pin), .fast_run_in(f_run), .fast_lock_in(f_lock),
    .fast_stab_in(f_stab), .mid_run_in(m_run), .sys_src(sys_src), .multiplier_on(mul_on),
    .cpu_hold(cpu_hold), .run_internal(run_int), .startup_done(st_done),
    .fast_osc_enable(f_en), .fast_startup_osc_enable(f_su), .fast_loop_enable(f_loop),
    .mid_osc_enable(m_en), .postscale_sel(psel), .fast_tune(f_tune), .mid_tune(m_tune),
    .primary_pin_gpio(pgpio), .secondary_pin_clock_out(s_ck), .secondary_pin_gpio(s_gpio)
  );

  clk_src_partner partner (
    .xtal_run(xtal_run), .fast_loop_enable(f_loop), .mid_osc_enable(m_en),
    .pin(pin), .fast_run(f_run), .fast_lock(f_lock), .fast_stab(f_stab), .mid_run(m_run)
  );

  // 200 MHz reference clock
  always #2.5 ref_clk = ~ref_clk;
  // crystal edges seen since the last start-up trigger
  always @(posedge pin) pin_edges++;

  task report_and_stop;
    if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // wait k edges; reads here see the values sampled at the last edge, and
  // any input driven afterwards changes on that edge by non-blocking assignment
  task tick(input int k);
    repeat (k) @(posedge ref_clk);
  endtask

  // write: address and data offered together, each released when taken
  task axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    k = 0;
    @(posedge ref_clk);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1 && k < 100);
    r = rsp.bresp;
    req.bready <= 1'b0;
    if (k >= 100) n_mismatch++;
  endtask

  task axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    k = 0;
    @(posedge ref_clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1 && k < 100);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
    if (k >= 100) n_mismatch++;
  endtask

  task wctl(input logic [1:0] scs, input logic [3:0] ifs, input logic sw);
    axi_wr(clk_src_pkg::CTRL_OFS, {24'h0, sw, ifs, 1'b0, scs}, rs);
    check(rs, clk_src_pkg::RESP_OKAY);
  endtask

  // trigger mid-period of the crystal so no pin edge straddles the restart
  task ost_run(input logic use_wake, input logic exp_hold);
    @(posedge pin);
    check(st_done, use_wake);
    repeat (8) @(posedge ref_clk);
    if (use_wake) wake <= 1'b1;
    else pwr_ok <= 1'b1;
    pin_edges = 0;
    @(posedge ref_clk);
    wake <= 1'b0;
    n = 0;
    while (pin_edges < OSTN - 2 && n < 2000) begin
      tick(1);
      n++;
    end
    check(st_done, 1'b0);
    check(cpu_hold, exp_hold);
    check(run_int, !exp_hold);
    n = 0;
    while (st_done !== 1'b1 && n < 2000) begin
      tick(1);
      n++;
    end
    tick(2);
    check(pin_edges, OSTN);
    check(cpu_hold, 1'b0);
    check(run_int, 1'b0);
    axi_rd(clk_src_pkg::STAT_OFS, rd, rs);
    check(rd[clk_src_pkg::OST_DONE_BIT], 1'b1);
  endtask

  // watchdog: the sequence needs well under 10 000 cycles
  initial begin
    #400000;
    n_mismatch++;
    report_and_stop;
  end

  // main sequence
  initial begin
    repeat (8) @(posedge ref_clk);
    check(cpu_hold, 1'b1);
    check(psel, 4'h7);
    check(sys_src, clk_src_pkg::SRC_PRIMARY);
    resetn <= 1'b1;
    axi_rd(clk_src_pkg::CTRL_OFS, rd, rs);
    check(rd, 32'h0000_0038);
    axi_rd(32'h0000_000c, rd, rs);
    check(rs, clk_src_pkg::RESP_SLVERR);
    check(rd, 32'h0000_0000);
    axi_wr(32'h0000_0010, 32'h0000_00ff, rs);
    check(rs, clk_src_pkg::RESP_SLVERR);
    // start-up after power-up, then wakes in the other two crystal modes,
    // with monitor and with dual-speed
    ost_run(1'b0, 1'b1);
    mon <= 1'b1;
    mode <= clk_src_pkg::MODE_MED_GAIN;
    ost_run(1'b1, 1'b0);
    mon <= 1'b0;
    dual <= 1'b1;
    mode <= clk_src_pkg::MODE_HIGH_GAIN;
    ost_run(1'b1, 1'b0);
    dual <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      cfg_mul <= i[1];
      wctl(2'h0, 4'h7, i[0]);
      tick(3);
      check(mul_on, i[1] | i[0]);
    end
    for (int i = 0; i < 4; i++) begin
      wctl(i[1:0], 4'h7, 1'b0);
      tick(3);
      check(sys_src, (i > 1) ? 32'h2 : 32'(i));
    end
    // oscillator enables and status over mode, select and frequency
    for (int m = 0; m < 2; m++) begin
      for (int s = 0; s < 2; s++) begin
        foreach (ifs_tab[k]) begin
          mode <= m ? clk_src_pkg::MODE_INTERNAL : clk_src_pkg::MODE_LOW_GAIN;
          wctl({s[0], 1'b0}, ifs_tab[k], 1'b0);
          tick(200);
          fe = (m || s) && ifs_tab[k] >= 4'h8;
          me = (m || s) && ifs_tab[k] >= 4'h2;
          check(f_en, fe);
          check(f_loop, fe);
          check(m_en, me);
          check(psel, ifs_tab[k]);
          axi_rd(clk_src_pkg::STAT_OFS, rd, rs);
          check(rd[3:0], {me, fe, fe, fe});
        end
      end
    end
    // fast start-up oscillator precedes the loop
    wctl(2'h0, 4'h0, 1'b0);
    tick(200);
    wctl(2'h0, 4'hf, 1'b0);
    n = 0;
    while (f_en !== 1'b1 && n < 50) begin
      tick(1);
      n++;
    end
    tick(1);
    check({f_su, f_loop}, 2'b10);
    tick(SETN + 2);
    check({f_su, f_loop}, 2'b01);
    axi_wr(clk_src_pkg::TUNE_OFS, 32'h0000_002a, rs);
    tick(3);
    check({f_tune, m_tune}, {6'h2a, 6'h2a});
    axi_rd(clk_src_pkg::TUNE_OFS, rd, rs);
    check(rd, 32'h0000_002a);
    foreach (mode_tab[k]) begin
      for (int b = 0; b < 2; b++) begin
        mode <= mode_tab[k];
        clk_out_cfg <= b[0];
        tick(3);
        check(pgpio, mode_tab[k] == 3'h4);
        check({s_ck, s_gpio}, (mode_tab[k] > 3'h2) ? {b[0], !b[0]} : 2'b00);
      end
    end
    // second reset in mid-run restores the select fields
    wctl(2'h2, 4'hf, 1'b1);
    resetn <= 1'b0;
    tick(2);
    check({sys_src, psel}, {clk_src_pkg::SRC_PRIMARY, 4'h7});
    @(posedge ref_clk);
    resetn <= 1'b1;
    axi_rd(clk_src_pkg::CTRL_OFS, rd, rs);
    check(rd, 32'h0000_0038);
    report_and_stop;
  end
endmodule
